// ==== pkg/afecr_pkg.sv ====
// constants, types and register layout of the analog front end control bank
package afecr_pkg;

	// ---------------------------------------------------------------
	// register addresses
	// ---------------------------------------------------------------
	localparam logic [2:0] AFECR_REG_MODE      = 3'h0;
	localparam logic [2:0] AFECR_REG_CLOCK     = 3'h1;
	localparam logic [2:0] AFECR_REG_POWER     = 3'h2;
	localparam logic [2:0] AFECR_REG_PAIR_ONE  = 3'h3;
	localparam logic [2:0] AFECR_REG_PAIR_TWO  = 3'h4;
	localparam logic [2:0] AFECR_REG_PAIR_THREE = 3'h5;
	localparam logic [2:0] AFECR_REG_INPUT_CFG = 3'h6;
	localparam logic [2:0] AFECR_REG_INVERT    = 3'h7;
	localparam int         AFECR_NUM_REGS      = 8;
	localparam int         AFECR_NUM_CH        = 6;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int AFECR_MODE_OP_BIT      = 0;
	localparam int AFECR_MODE_MIXED_BIT   = 1;
	localparam int AFECR_MODE_LOOP_BIT    = 3;
	localparam int AFECR_MODE_CASCADE_LSB = 4;
	localparam int AFECR_MODE_SWRST_BIT   = 7;
	localparam int AFECR_CLK_DEC_LSB      = 0;
	localparam int AFECR_CLK_SCLK_LSB     = 2;
	localparam int AFECR_CLK_MCD_LSB      = 4;
	localparam int AFECR_CLK_ECHO_BIT     = 7;
	localparam int AFECR_PWR_GLOBAL_BIT   = 0;
	localparam int AFECR_PWR_REF_BIT      = 5;
	localparam int AFECR_PWR_REF_OUT_BIT  = 6;
	localparam int AFECR_PAIR_HALF        = 4;
	localparam int AFECR_PAIR_PWR_BIT     = 3;
	localparam int AFECR_CFG_MODRST_BIT   = 6;
	localparam int AFECR_CFG_SE_BIT       = 7;
	localparam int AFECR_FLIP_TEST_BIT    = 6;
	localparam int AFECR_FLIP_EN_BIT      = 7;

	// ---------------------------------------------------------------
	// reset values and timing counts
	// ---------------------------------------------------------------
	localparam logic [7:0]  AFECR_REG_RESET_VAL  = 8'h00;
	localparam logic [2:0]  AFECR_RESET_DIV_CLKS = 3'h4;
	localparam logic [2:0]  AFECR_SCLK_MASK_DIV8 = 3'h7;
	localparam logic [2:0]  AFECR_SCLK_MASK_DIV4 = 3'h3;
	localparam logic [2:0]  AFECR_SCLK_MASK_DIV2 = 3'h1;
	localparam logic [2:0]  AFECR_SCLK_MASK_DIV1 = 3'h0;
	localparam logic [10:0] AFECR_DEC_MASK_2048  = 11'h7ff;
	localparam logic [10:0] AFECR_DEC_MASK_1024  = 11'h3ff;
	localparam logic [10:0] AFECR_DEC_MASK_512   = 11'h1ff;
	localparam logic [10:0] AFECR_DEC_MASK_256   = 11'h0ff;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		AFECR_PROGRAM = 2'h0,
		AFECR_DATA    = 2'h1,
		AFECR_MIXED   = 2'h3
	} afecr_mode_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] data;
	} afecr_cword_t;

endpackage : afecr_pkg

// ==== test/afecr_host.sv ====
// host model that issues control words to the control bank
`timescale 1ns/1ps
module afecr_host
	import afecr_pkg::*;
(
	// clock
	input  wire logic       core_clk,
	// control words out
	output afecr_cword_t    cword,
	// readback in
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid
);
	initial cword = '0;

	// ---------------------------------------------------------------
	// write: reserved bits zeroed, diagnostic bits only on request
	// ---------------------------------------------------------------
	task automatic write(input logic [2:0] a, input logic [7:0] d, input bit diag);
		logic [7:0] v;
		v = d;
		if (a == AFECR_REG_MODE) v[2] = 1'b0;
		if (a == AFECR_REG_POWER) v = v & 8'h61;
		if (!diag && a == AFECR_REG_MODE) v[AFECR_MODE_LOOP_BIT] = 1'b0;
		if (!diag && a == AFECR_REG_CLOCK) v[AFECR_CLK_ECHO_BIT] = 1'b0;
		if (!diag && a == AFECR_REG_INPUT_CFG) v[AFECR_CFG_MODRST_BIT] = 1'b0;
		if (!diag && a == AFECR_REG_INVERT) v[AFECR_FLIP_TEST_BIT] = 1'b0;
		// single device: count sent as given, same for all
		@(posedge core_clk);
		cword <= '{wr: 1'b1, rd: 1'b0, addr: a, data: v};
		@(posedge core_clk);
		cword <= '0;
	endtask : write

	// ---------------------------------------------------------------
	// read: answer sampled just after the edge that takes the request
	// ---------------------------------------------------------------
	task automatic read(input logic [2:0] a, output logic [7:0] d, output logic v);
		@(posedge core_clk);
		cword <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(posedge core_clk);
		cword <= '0;
		#1;
		v = rd_valid;
		d = rd_data;
	endtask : read
endmodule : afecr_host

// ==== test/testbench.sv ====
// self-checking bench for the control bank
`timescale 1ns/1ps
`define CHK(g, e, msg) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t %s", $time, msg); end end
module testbench;
	import afecr_pkg::*;
	logic              core_clk, rst_n, rd_valid, serial_loopback, control_echo, reset_busy;
	logic              divided_master_clock, serial_clock_tick, sample_tick, reference_power_up;
	logic              reference_out_pin, test_mode_enable;
	afecr_cword_t      cword;
	afecr_mode_t       op_mode_select;
	logic [7:0]        rd_data;
	logic [2:0]        cascade_count;
	logic [5:0]        adc_power, modulator_reset, single_ended, polarity_flip;
	logic [5:0][2:0]   adc_gain_select;
	logic [7:0]        m [8];
	int                n_errors = 0;
	int                samples_checked = 0;
	int                p, n;
	// {diag, addr, data}
	logic [11:0] rows [21] = '{12'h001, 12'h000, 12'h002, 12'h053, 12'h879, 12'h11b, 12'h980, 12'h100,
		12'h201, 12'h220, 12'h240, 12'h200, 12'h3a5, 12'h458, 12'h5f7, 12'h6bf, 12'he45, 12'h63f,
		12'h7a9, 12'h72a, 12'hfc1};

	afecr_bank dut_u (.core_clk, .rst_n, .cword, .rd_data, .rd_valid, .op_mode_select, .cascade_count,
		.serial_loopback, .control_echo, .reset_busy, .divided_master_clock, .serial_clock_tick,
		.sample_tick, .reference_power_up, .reference_out_pin, .adc_power, .adc_gain_select,
		.modulator_reset, .single_ended, .polarity_flip, .test_mode_enable);
	afecr_host host_u (.core_clk, .cword, .rd_data, .rd_valid);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ---------------------------------------------------------------
	// shared checks
	// ---------------------------------------------------------------
	task automatic check_outputs();
		logic [5:0]  pw;
		afecr_mode_t em;
		em = m[0][1] ? AFECR_MIXED : (m[0][0] ? AFECR_DATA : AFECR_PROGRAM);
		`CHK(op_mode_select, em, "mode")
		`CHK(cascade_count, m[0][6:4], "cascade")
		`CHK(serial_loopback, m[0][3], "loopback")
		`CHK(control_echo, m[1][7], "echo")
		for (int ch = 0; ch < 6; ch++) begin
			pw[ch] = m[3 + ch / 2][(ch % 2) ? 7 : 3] | m[2][0];
			`CHK(adc_gain_select[ch], 3'(m[3 + ch / 2] >> (4 * (ch % 2))), "gain")
		end
		`CHK(adc_power, pw, "power")
		`CHK(reference_power_up, m[2][5] | (|pw), "reference")
		`CHK(reference_out_pin, m[2][6], "reference_out_pin")
		`CHK(modulator_reset, m[6][5:0] & {6{m[6][6]}}, "modrst")
		`CHK(single_ended, m[6][5:0] & {6{m[6][7]}}, "single ended")
		`CHK(polarity_flip, m[7][5:0] & {6{m[7][7]}}, "invert")
		`CHK(test_mode_enable, m[7][6], "test mode")
	endtask : check_outputs

	task automatic wr_chk(input logic [11:0] r);
		host_u.write(r[10:8], r[7:0], r[11]);
		m[r[10:8]] = r[7:0];
		repeat (2) @(posedge core_clk);
		#1;
		check_outputs();
	endtask : wr_chk

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		host_u.read(a, d, v);
		`CHK(v, 1'b1, "read valid")
		`CHK(d, e, "readback")
		@(posedge core_clk);
		#1;
		`CHK(rd_valid, 1'b0, "read valid held too long")
		`CHK(rd_data, 8'h00, "read data held too long")
	endtask : rd_chk

	task automatic wait_idle(output int cnt);
		cnt = 0;
		while (reset_busy !== 1'b0 && cnt < 100) begin
			@(posedge core_clk);
			#1;
			cnt++;
		end
	endtask : wait_idle

	function automatic logic pulse(input int w);
		return (w == 0) ? divided_master_clock : ((w == 1) ? serial_clock_tick : sample_tick);
	endfunction : pulse

	task automatic period(input int w, output int q);
		int k;
		k = 0;
		while (pulse(w) !== 1'b1 && k < 20000) begin
			@(posedge core_clk);
			#1;
			k++;
		end
		q = 0;
		do begin
			@(posedge core_clk);
			#1;
			q++;
		end while (pulse(w) !== 1'b1 && q < 20000);
	endtask : period

	task automatic tally_and_finish();
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		foreach (m[i]) m[i] = 8'h00;
		repeat (10) @(posedge core_clk);
		#1;
		check_outputs();
		`CHK(reset_busy, 1'b1, "busy in reset")
		@(posedge core_clk);
		rst_n <= 1'b1;
		host_u.write(AFECR_REG_POWER, 8'h01, 1'b0);
		wait_idle(n);
		`CHK(n >= 2 && n <= 6, 1'b1, "reset length")
		check_outputs();
		rd_chk(AFECR_REG_POWER, 8'h00);
		foreach (rows[i]) wr_chk(rows[i]);
		for (int a = 0; a < 8; a++) rd_chk(3'(a), m[a]);
		for (int c = 0; c < 8; c++) begin
			host_u.write(AFECR_REG_CLOCK, {1'b0, 3'(c), 2'(c), 2'(c)}, 1'b0);
			n = (c < 5) ? c + 1 : 1;
			repeat (2) period(0, p);
			`CHK(p, n, "divided clock period")
			repeat (2) period(1, p);
			`CHK(p, n * (8 >> (c % 4)), "serial clock period")
			if (c < 4) begin
				repeat (2) period(2, p);
				`CHK(p, n * (2048 >> c), "sample period")
			end
		end
		wr_chk(12'h3ff);
		host_u.write(AFECR_REG_MODE, 8'hd1, 1'b0);
		foreach (m[i]) m[i] = 8'h00;
		@(posedge core_clk);
		#1;
		`CHK(reset_busy, 1'b1, "software reset start")
		wait_idle(n);
		`CHK(n >= 2 && n <= 6, 1'b1, "software reset length")
		check_outputs();
		for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00);
		wr_chk(12'h201);
		tally_and_finish();
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		tally_and_finish();
	end
endmodule : testbench

// ==== verilog/afecr_bank.sv ====
// eight-register control bank with clock dividers and per-channel controls
`timescale 1ns/1ps
module afecr_bank
	import afecr_pkg::*;
(
	// clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	// decoded control words
	input  wire afecr_cword_t                cword,
	// readback
	output logic [7:0]                       rd_data,
	output logic                             rd_valid,
	// mode and link settings
	output afecr_mode_t                      op_mode_select,
	output logic [2:0]                       cascade_count,
	output logic                             serial_loopback,
	output logic                             control_echo,
	output logic                             reset_busy,
	// clock enables
	output logic                             divided_master_clock,
	output logic                             serial_clock_tick,
	output logic                             sample_tick,
	// reference and power
	output logic                             reference_power_up,
	output logic                             reference_out_pin,
	output logic [AFECR_NUM_CH-1:0]          adc_power,
	output logic [AFECR_NUM_CH-1:0][2:0]     adc_gain_select,
	// channel input path
	output logic [AFECR_NUM_CH-1:0]          modulator_reset,
	output logic [AFECR_NUM_CH-1:0]          single_ended,
	output logic [AFECR_NUM_CH-1:0]          polarity_flip,
	output logic                             test_mode_enable
);

	// ---------------------------------------------------------------
	// register storage
	// ---------------------------------------------------------------
	logic [7:0]  ctrl_reg [0:AFECR_NUM_REGS-1];
	logic [2:0]  reset_left;
	logic        write_ok;
	logic        sw_reset;
	logic [2:0]  mcd_code;
	logic [2:0]  div_last;
	logic [2:0]  mc_cnt;
	logic [2:0]  sc_cnt;
	logic [2:0]  sclk_mask;
	logic [10:0] dec_cnt;
	logic [10:0] dec_mask;
	logic        any_power;

	// writes are ignored while a reset sequence runs
	assign write_ok = cword.wr && (reset_left == 3'h0);
	assign sw_reset = write_ok && (cword.addr == AFECR_REG_MODE) && cword.data[AFECR_MODE_SWRST_BIT];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < AFECR_NUM_REGS; i++) begin
				ctrl_reg[i] <= AFECR_REG_RESET_VAL;
			end
		end else if (sw_reset) begin
			for (int i = 0; i < AFECR_NUM_REGS; i++) begin
				ctrl_reg[i] <= AFECR_REG_RESET_VAL;
			end
		end else if (write_ok) begin
			ctrl_reg[cword.addr] <= cword.data;
		end
	end

	// ---------------------------------------------------------------
	// reset sequence, four divided clocks long
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_left <= AFECR_RESET_DIV_CLKS;
			reset_busy <= 1'b1;
		end else if (sw_reset) begin
			reset_left <= AFECR_RESET_DIV_CLKS;
			reset_busy <= 1'b1;
		end else if (divided_master_clock && reset_left != 3'h0) begin
			reset_left <= reset_left - 3'h1;
			reset_busy <= (reset_left != 3'h1);
		end
	end

	// ---------------------------------------------------------------
	// master clock divider
	// ---------------------------------------------------------------
	assign mcd_code = ctrl_reg[AFECR_REG_CLOCK][AFECR_CLK_MCD_LSB +: 3];

	always_comb begin
		case (mcd_code)
			3'h1:    div_last = 3'h1;
			3'h2:    div_last = 3'h2;
			3'h3:    div_last = 3'h3;
			3'h4:    div_last = 3'h4;
			default: div_last = 3'h0;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mc_cnt               <= 3'h0;
			divided_master_clock <= 1'b0;
		end else begin
			mc_cnt               <= (mc_cnt >= div_last) ? 3'h0 : mc_cnt + 3'h1;
			divided_master_clock <= (mc_cnt >= div_last);
		end
	end

	// ---------------------------------------------------------------
	// serial clock and sample rate dividers
	// ---------------------------------------------------------------
	always_comb begin
		case (ctrl_reg[AFECR_REG_CLOCK][AFECR_CLK_SCLK_LSB +: 2])
			2'h0:    sclk_mask = AFECR_SCLK_MASK_DIV8;
			2'h1:    sclk_mask = AFECR_SCLK_MASK_DIV4;
			2'h2:    sclk_mask = AFECR_SCLK_MASK_DIV2;
			default: sclk_mask = AFECR_SCLK_MASK_DIV1;
		endcase
	end

	always_comb begin
		case (ctrl_reg[AFECR_REG_CLOCK][AFECR_CLK_DEC_LSB +: 2])
			2'h0:    dec_mask = AFECR_DEC_MASK_2048;
			2'h1:    dec_mask = AFECR_DEC_MASK_1024;
			2'h2:    dec_mask = AFECR_DEC_MASK_512;
			default: dec_mask = AFECR_DEC_MASK_256;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sc_cnt            <= 3'h0;
			serial_clock_tick <= 1'b0;
		end else begin
			if (divided_master_clock) begin
				sc_cnt <= sc_cnt + 3'h1;
			end
			serial_clock_tick <= divided_master_clock && ((sc_cnt & sclk_mask) == sclk_mask);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_cnt     <= 11'h000;
			sample_tick <= 1'b0;
		end else begin
			if (divided_master_clock) begin
				dec_cnt <= dec_cnt + 11'h001;
			end
			sample_tick <= divided_master_clock && ((dec_cnt & dec_mask) == dec_mask);
		end
	end

	// ---------------------------------------------------------------
	// mode and link settings
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_mode_select  <= AFECR_PROGRAM;
			cascade_count   <= 3'h0;
			serial_loopback <= 1'b0;
			control_echo    <= 1'b0;
		end else begin
			if (ctrl_reg[AFECR_REG_MODE][AFECR_MODE_MIXED_BIT]) begin
				op_mode_select <= AFECR_MIXED;
			end else if (ctrl_reg[AFECR_REG_MODE][AFECR_MODE_OP_BIT]) begin
				op_mode_select <= AFECR_DATA;
			end else begin
				op_mode_select <= AFECR_PROGRAM;
			end
			cascade_count   <= ctrl_reg[AFECR_REG_MODE][AFECR_MODE_CASCADE_LSB +: 3];
			serial_loopback <= ctrl_reg[AFECR_REG_MODE][AFECR_MODE_LOOP_BIT];
			control_echo    <= ctrl_reg[AFECR_REG_CLOCK][AFECR_CLK_ECHO_BIT];
		end
	end

	// ---------------------------------------------------------------
	// readback of the selected register
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_data  <= cword.rd ? ctrl_reg[cword.addr] : 8'h00;
			rd_valid <= cword.rd;
		end
	end

	// ---------------------------------------------------------------
	// reference control
	// ---------------------------------------------------------------
	always_comb begin
		any_power = ctrl_reg[AFECR_REG_POWER][AFECR_PWR_GLOBAL_BIT];
		for (int i = 0; i < AFECR_NUM_CH; i++) begin
			any_power = any_power | ctrl_reg[AFECR_REG_PAIR_ONE + i / 2][(i % 2) * AFECR_PAIR_HALF + AFECR_PAIR_PWR_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reference_power_up <= 1'b0;
			reference_out_pin  <= 1'b0;
			test_mode_enable   <= 1'b0;
		end else begin
			reference_power_up <= ctrl_reg[AFECR_REG_POWER][AFECR_PWR_REF_BIT] | any_power;
			reference_out_pin  <= ctrl_reg[AFECR_REG_POWER][AFECR_PWR_REF_OUT_BIT];
			test_mode_enable   <= ctrl_reg[AFECR_REG_INVERT][AFECR_FLIP_TEST_BIT];
		end
	end

	// ---------------------------------------------------------------
	// per-channel controls
	// ---------------------------------------------------------------
	for (genvar ch = 0; ch < AFECR_NUM_CH; ch++) begin : g_ch
		localparam int PAIR = AFECR_REG_PAIR_ONE + ch / 2;
		localparam int LSB  = (ch % 2) * AFECR_PAIR_HALF;
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				adc_power[ch]       <= 1'b0;
				adc_gain_select[ch] <= 3'h0;
				modulator_reset[ch] <= 1'b0;
				single_ended[ch]    <= 1'b0;
				polarity_flip[ch]   <= 1'b0;
			end else begin
				adc_power[ch]       <= ctrl_reg[PAIR][LSB + AFECR_PAIR_PWR_BIT]
					| ctrl_reg[AFECR_REG_POWER][AFECR_PWR_GLOBAL_BIT];
				adc_gain_select[ch] <= ctrl_reg[PAIR][LSB +: 3];
				modulator_reset[ch] <= ctrl_reg[AFECR_REG_INPUT_CFG][AFECR_CFG_MODRST_BIT]
					& ctrl_reg[AFECR_REG_INPUT_CFG][ch];
				single_ended[ch]    <= ctrl_reg[AFECR_REG_INPUT_CFG][AFECR_CFG_SE_BIT]
					& ctrl_reg[AFECR_REG_INPUT_CFG][ch];
				polarity_flip[ch]   <= ctrl_reg[AFECR_REG_INVERT][AFECR_FLIP_EN_BIT]
					& ctrl_reg[AFECR_REG_INVERT][ch];
			end
		end

		AST_UNSELECTED_PLAIN: assert property (@(posedge core_clk) disable iff (!rst_n)
			!ctrl_reg[AFECR_REG_INPUT_CFG][ch] |=> !modulator_reset[ch] && !single_ended[ch])
			else $error("unselected channel not differential or modulator reset");
		AST_INVERT_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
			ctrl_reg[AFECR_REG_INVERT][AFECR_FLIP_EN_BIT]
			|=> polarity_flip[ch] == $past(ctrl_reg[AFECR_REG_INVERT][ch]))
			else $error("channel inversion does not follow its select");
		AST_GAIN_FIELD: assert property (@(posedge core_clk) disable iff (!rst_n)
			!cword.wr ##1 !cword.wr |-> adc_gain_select[ch] == ctrl_reg[PAIR][LSB +: 3])
			else $error("gain select not taken from pair register");
		AST_CH_POWER: assert property (@(posedge core_clk) disable iff (!rst_n)
			ctrl_reg[PAIR][LSB + AFECR_PAIR_PWR_BIT] |=> adc_power[ch])
			else $error("channel power bit set but converter powered down");
	end
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_sw_reset_req;
		sw_reset;
	endsequence
	sequence s_reset_run;
		reset_busy [*4];
	endsequence
	sequence s_five_quiet;
		(divided_master_clock && div_last == 3'h4 && !cword.wr) ##1 (!divided_master_clock && !cword.wr) [*3];
	endsequence

	AST_MODE_PROGRAM_DATA: assert property (
		!ctrl_reg[AFECR_REG_MODE][AFECR_MODE_MIXED_BIT]
		|=> op_mode_select == ($past(ctrl_reg[AFECR_REG_MODE][AFECR_MODE_OP_BIT]) ? AFECR_DATA : AFECR_PROGRAM))
		else $error("operating mode does not follow mode bit");
	AST_MODE_MIXED: assert property (
		ctrl_reg[AFECR_REG_MODE][AFECR_MODE_MIXED_BIT] |=> op_mode_select == AFECR_MIXED)
		else $error("mixed bit set but not in mixed mode");
	AST_CASCADE: assert property (
		!cword.wr ##1 !cword.wr |-> cascade_count == ctrl_reg[AFECR_REG_MODE][AFECR_MODE_CASCADE_LSB +: 3])
		else $error("cascade count output wrong");
	AST_SW_RESET: assert property (
		s_sw_reset_req |=> ctrl_reg[AFECR_REG_MODE] == 8'h00 && ctrl_reg[AFECR_REG_INVERT] == 8'h00 ##1
		op_mode_select == AFECR_PROGRAM)
		else $error("software reset did not clear registers");
	AST_RESET_LENGTH: assert property (
		s_sw_reset_req |=> s_reset_run ##[1:16] !reset_busy)
		else $error("reset sequence length wrong");
	AST_DIV_CLOCK_BY_FIVE: assert property (
		s_five_quiet |=> !divided_master_clock ##1 divided_master_clock)
		else $error("divide by five period wrong");
	AST_DIV_CLOCK_HIGH_CODES: assert property (
		mcd_code >= 3'h5 |=> divided_master_clock)
		else $error("high divider code not dividing by one");
	AST_SCLK_FULL_RATE: assert property (
		divided_master_clock && ctrl_reg[AFECR_REG_CLOCK][AFECR_CLK_SCLK_LSB +: 2] == 2'h3 |=> serial_clock_tick)
		else $error("serial clock not at divided clock rate");
	AST_SAMPLE_ALIGN: assert property (
		sample_tick |-> $past(divided_master_clock) && ($past(dec_cnt) & AFECR_DEC_MASK_256) == AFECR_DEC_MASK_256)
		else $error("sample tick off its divider boundary");
	AST_GLOBAL_POWER: assert property (
		ctrl_reg[AFECR_REG_POWER][AFECR_PWR_GLOBAL_BIT] |=> &adc_power)
		else $error("global power bit did not power all channels");
	AST_REF_AUTO: assert property (
		|adc_power |-> reference_power_up)
		else $error("channel powered without reference");
	AST_REFERENCE_OUT_PIN: assert property (
		!cword.wr ##1 !cword.wr |-> reference_out_pin == ctrl_reg[AFECR_REG_POWER][AFECR_PWR_REF_OUT_BIT])
		else $error("reference output enable wrong");
	AST_HOLD: assert property (
		!cword.wr |=> $stable(ctrl_reg[AFECR_REG_CLOCK]) && $stable(ctrl_reg[AFECR_REG_POWER]))
		else $error("register changed without a write");

endmodule : afecr_bank
